// ### rtl/fsa_annunciator.sv
// Fault status annunciator with APB registers
`timescale 1ns/1ns
`include "fsa_defs.svh"

//Behaviour
// - Latch five distinct faults, each with its own lamp pattern.
// - Blink code, then half-second gap, then repeat forever.
// - Latched faults persist; only power-on reset clears them.
// - Over temperature: ready lamp flashes, power lamp steady, lasing inhibited.
// - Over temperature: emitter-OK low, thermal-OK low, supply-OK high, emission off.
// - Under voltage: single blink on power lamp, repeated after gaps.
// - Over voltage: two blinks on power lamp, repeated after gaps.
// - DC sense: three blinks on power lamp, repeated after gaps.
// - Supply fault: ready and emission off; emitter low, thermal high, supply low.
// - PWM sense fault: ready and power lamps flash, lasing inhibited.
// - PWM sense fault: emitter-OK low, thermal and supply high, emission off.
// - No enable, no fault: power on, ready off, emitter low, others high.
// - Enable loss is not latched; returning enable permits lasing at once.
// - After reset with no fault, ready lamp is steady, not flashing.
// - Enabled and fault free: ready lamp on, tickle and PWM pass through.
// - Emission lamp lit only while long enough PWM pulses pass.
// - Normal ready operation: all three OK outputs high, power and ready on.
module fsa_annunciator import fsa_pkg::*; #(
  parameter int PHASE_CYC = `FSA_PHASE_CYC,
  parameter int MIN_PWM_CYC = `FSA_MIN_PWM_CYC
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FSA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault condition inputs
  input wire logic over_temp,
  input wire logic under_volt,
  input wire logic over_volt,
  input wire logic dc_sense,
  input wire logic pwm_sense,
  // Controller commands
  input wire logic laser_enable,
  input wire logic tickle_cmd,
  input wire logic pwm_cmd,
  // RF driver commands
  output logic rf_tickle,
  output logic rf_pwm,
  // Indicator lamps
  output logic ready_lamp,
  output logic power_lamp,
  output logic emission_lamp,
  // Status connector outputs
  output logic emitter_ok,
  output logic thermal_ok,
  output logic supply_ok,
  // Interrupt
  output logic irq
);

  localparam int PW = $clog2(PHASE_CYC + 1);
  localparam int MW = $clog2(MIN_PWM_CYC + 1);

  // Display priority
  function automatic fsa_mode_t fsa_mode(input logic [`FSA_NFAULT-1:0] f);
    fsa_mode_t m;
    m = FSA_MODE_OK;
    if (f[`FSA_F_PWM]) begin
      m = FSA_MODE_PWM;
    end else if (f[`FSA_F_OT]) begin
      m = FSA_MODE_OT;
    end else if (f[`FSA_F_UV] || f[`FSA_F_OV] || f[`FSA_F_DC]) begin
      m = FSA_MODE_SUPPLY;
    end
    return m;
  endfunction

  // Blink count for the highest supply fault
  function automatic logic [1:0] fsa_code(input logic [`FSA_NFAULT-1:0] f);
    logic [1:0] c;
    c = 2'h0;
    if (f[`FSA_F_UV]) begin
      c = 2'h1;
    end else if (f[`FSA_F_OV]) begin
      c = 2'h2;
    end else if (f[`FSA_F_DC]) begin
      c = 2'h3;
    end
    return c;
  endfunction

  logic [`FSA_NFAULT-1:0] fault_in;
  logic [`FSA_NFAULT-1:0] fault_ff;
  logic ctrl_sw_en_ff;
  logic [`FSA_NEV-1:0] irq_stat_ff;
  logic [`FSA_NEV-1:0] irq_mask_ff;
  logic [`FSA_NEV-1:0] nxt_irq_stat;
  logic [`FSA_NEV-1:0] events;
  logic enable_prev_ff;
  logic [31:0] prdata_ff;
  logic [PW-1:0] presc_ff;
  logic tick_ff;
  logic [MW-1:0] pwm_run_ff;
  logic rf_tickle_ff;
  logic rf_pwm_ff;
  logic ready_lamp_ff;
  logic power_lamp_ff;
  logic emission_lamp_ff;
  logic emitter_ok_ff;
  logic thermal_ok_ff;
  logic supply_ok_ff;
  logic irq_ff;
  logic any_fault;
  logic lase_ok;
  logic flash_lamp;
  logic code_lamp;
  logic code_run;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  fsa_mode_t mode;

  assign fault_in[`FSA_F_OT] = over_temp;
  assign fault_in[`FSA_F_UV] = under_volt;
  assign fault_in[`FSA_F_OV] = over_volt;
  assign fault_in[`FSA_F_DC] = dc_sense;
  assign fault_in[`FSA_F_PWM] = pwm_sense;

  assign any_fault = |fault_ff;
  assign mode = fsa_mode(fault_ff);
  assign lase_ok = laser_enable && !any_fault;

  // Fault latches, cleared only by power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= '0;
    end else begin
      fault_ff <= fault_ff | fault_in;
    end
  end

  // Phase tick prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= '0;
      tick_ff <= 1'b0;
    end else if (presc_ff == PW'(PHASE_CYC - 1)) begin
      presc_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      presc_ff <= presc_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Continuous flash pattern
  fsa_blinker #(
    .GAP_TICKS(`FSA_GAP_TICKS)
  ) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_ff),
    .run(mode == FSA_MODE_PWM || mode == FSA_MODE_OT),
    .code(2'h0),
    .lamp(flash_lamp)
  );

  // Counted blink code pattern
  assign code_run = mode == FSA_MODE_SUPPLY;

  fsa_blinker #(
    .GAP_TICKS(`FSA_GAP_TICKS)
  ) u_code (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_ff),
    .run(code_run),
    .code(fsa_code(fault_ff)),
    .lamp(code_lamp)
  );

  // Ready lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_lamp_ff <= 1'b0;
    end else begin
      case (mode)
        FSA_MODE_PWM: ready_lamp_ff <= flash_lamp;
        FSA_MODE_OT: ready_lamp_ff <= flash_lamp;
        FSA_MODE_SUPPLY: ready_lamp_ff <= 1'b0;
        default: ready_lamp_ff <= laser_enable;
      endcase
    end
  end

  // Power lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_lamp_ff <= 1'b0;
    end else begin
      case (mode)
        FSA_MODE_PWM: power_lamp_ff <= flash_lamp;
        FSA_MODE_SUPPLY: power_lamp_ff <= code_lamp;
        FSA_MODE_OT: power_lamp_ff <= 1'b1;
        default: power_lamp_ff <= 1'b1;
      endcase
    end
  end

  // Status connector outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emitter_ok_ff <= 1'b0;
      thermal_ok_ff <= 1'b0;
      supply_ok_ff <= 1'b0;
    end else begin
      emitter_ok_ff <= lase_ok;
      thermal_ok_ff <= !fault_ff[`FSA_F_OT];
      supply_ok_ff <= !(fault_ff[`FSA_F_UV] || fault_ff[`FSA_F_OV] || fault_ff[`FSA_F_DC]);
    end
  end

  // PWM pulse length measure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_run_ff <= '0;
    end else if (!pwm_cmd) begin
      pwm_run_ff <= '0;
    end else if (pwm_run_ff != MW'(MIN_PWM_CYC)) begin
      pwm_run_ff <= pwm_run_ff + 1'b1;
    end
  end

  // RF command pass-through and emission lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_tickle_ff <= 1'b0;
      rf_pwm_ff <= 1'b0;
      emission_lamp_ff <= 1'b0;
    end else begin
      rf_tickle_ff <= lase_ok && ctrl_sw_en_ff && tickle_cmd;
      rf_pwm_ff <= lase_ok && ctrl_sw_en_ff && pwm_cmd;
      emission_lamp_ff <= lase_ok && ctrl_sw_en_ff && pwm_cmd
                          && pwm_run_ff == MW'(MIN_PWM_CYC);
    end
  end

  // APB decode
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    if (paddr == `FSA_CTRL_OFF) begin
      addr_hit = 1'b1;
    end else if (paddr == `FSA_STATUS_OFF) begin
      addr_hit = 1'b1;
    end else if (paddr == `FSA_IRQ_STAT_OFF) begin
      addr_hit = 1'b1;
    end else if (paddr == `FSA_IRQ_MASK_OFF) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw_en_ff <= `FSA_CTRL_RST;
    end else if (wr_en && paddr == `FSA_CTRL_OFF) begin
      ctrl_sw_en_ff <= pwdata[`FSA_CTRL_SW_EN];
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= `FSA_MASK_RST;
    end else if (wr_en && paddr == `FSA_IRQ_MASK_OFF) begin
      irq_mask_ff <= pwdata[`FSA_NEV-1:0];
    end
  end

  // Interrupt events: new fault latch and enable loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_prev_ff <= 1'b0;
    end else begin
      enable_prev_ff <= laser_enable;
    end
  end

  assign events[`FSA_NFAULT-1:0] = fault_in & ~fault_ff;
  assign events[`FSA_EV_ILK] = enable_prev_ff && !laser_enable;

  // Sticky status, write one to clear, set wins
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && paddr == `FSA_IRQ_STAT_OFF) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[`FSA_NEV-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (rd_setup) begin
      if (paddr == `FSA_CTRL_OFF) begin
        prdata_ff <= {31'h0, ctrl_sw_en_ff};
      end else if (paddr == `FSA_STATUS_OFF) begin
        prdata_ff <= {24'h0, emission_lamp_ff, rf_pwm_ff | rf_tickle_ff | lase_ok, laser_enable, fault_ff};
      end else if (paddr == `FSA_IRQ_STAT_OFF) begin
        prdata_ff <= {26'h0, irq_stat_ff};
      end else if (paddr == `FSA_IRQ_MASK_OFF) begin
        prdata_ff <= {26'h0, irq_mask_ff};
      end else begin
        prdata_ff <= 32'h0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  assign rf_tickle = rf_tickle_ff;
  assign rf_pwm = rf_pwm_ff;
  assign ready_lamp = ready_lamp_ff;
  assign power_lamp = power_lamp_ff;
  assign emission_lamp = emission_lamp_ff;
  assign emitter_ok = emitter_ok_ff;
  assign thermal_ok = thermal_ok_ff;
  assign supply_ok = supply_ok_ff;
  assign irq = irq_ff;

endmodule

// ### rtl/fsa_defs.svh
// Constants for the fault status annunciator
`ifndef FSA_DEFS_SVH
`define FSA_DEFS_SVH

// Clock and lamp timing
`define FSA_CLK_PERIOD_NS 10
`define FSA_PHASE_MS 250
`define FSA_GAP_MS 500
`define FSA_PHASE_CYC ((`FSA_PHASE_MS * 1000000) / `FSA_CLK_PERIOD_NS)
`define FSA_GAP_TICKS (`FSA_GAP_MS / `FSA_PHASE_MS)
`define FSA_MIN_PWM_NS 2000
`define FSA_MIN_PWM_CYC ((`FSA_MIN_PWM_NS + `FSA_CLK_PERIOD_NS - 1) / `FSA_CLK_PERIOD_NS)

// Register byte offsets
`define FSA_ADDR_W 12
`define FSA_CTRL_OFF 12'h000
`define FSA_STATUS_OFF 12'h004
`define FSA_IRQ_STAT_OFF 12'h008
`define FSA_IRQ_MASK_OFF 12'h00c

// Fault bit positions, shared by status and interrupt registers
`define FSA_F_OT 0
`define FSA_F_UV 1
`define FSA_F_OV 2
`define FSA_F_DC 3
`define FSA_F_PWM 4
`define FSA_NFAULT 5
`define FSA_EV_ILK 5
`define FSA_NEV 6
`define FSA_ST_ENABLE 5
`define FSA_ST_LASING 6
`define FSA_ST_EMISSION 7
`define FSA_CTRL_SW_EN 0

// Reset values
`define FSA_CTRL_RST 1'h1
`define FSA_MASK_RST 6'h00

`endif

// ### rtl/fsa_pkg.sv
// Types for the fault status annunciator
package fsa_pkg;

  typedef enum logic [1:0] {
    FSA_MODE_OK,
    FSA_MODE_PWM,
    FSA_MODE_OT,
    FSA_MODE_SUPPLY
  } fsa_mode_t;

  typedef enum logic [1:0] {
    FSA_BL_ON,
    FSA_BL_OFF,
    FSA_BL_GAP
  } fsa_blink_t;

endpackage

// ### rtl/fsa_blinker.sv
// Lamp pattern generator: continuous flash or counted blink code
`timescale 1ns/1ns
`include "fsa_defs.svh"
module fsa_blinker import fsa_pkg::*; #(
  parameter int GAP_TICKS = `FSA_GAP_TICKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pattern control
  input wire logic tick,
  input wire logic run,
  input wire logic [1:0] code,
  // Lamp drive
  output logic lamp
);

  localparam int GW = $clog2(GAP_TICKS + 1);

  fsa_blink_t state_ff;
  logic [1:0] count_ff;
  logic [GW-1:0] gap_ff;
  logic lamp_ff;

  // Blink sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FSA_BL_ON;
      count_ff <= 2'h0;
      gap_ff <= '0;
    end else if (!run) begin
      state_ff <= FSA_BL_ON;
      count_ff <= 2'h0;
      gap_ff <= '0;
    end else if (tick) begin
      case (state_ff)
        FSA_BL_ON: begin
          if (code != 2'h0 && count_ff == code - 2'h1) begin
            state_ff <= FSA_BL_GAP;
            gap_ff <= '0;
          end else begin
            state_ff <= FSA_BL_OFF;
          end
        end
        FSA_BL_OFF: begin
          state_ff <= FSA_BL_ON;
          count_ff <= (code == 2'h0) ? 2'h0 : count_ff + 2'h1;
        end
        FSA_BL_GAP: begin
          if (gap_ff == GW'(GAP_TICKS - 1)) begin
            state_ff <= FSA_BL_ON;
            count_ff <= 2'h0;
          end else begin
            gap_ff <= gap_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= FSA_BL_ON;
        end
      endcase
    end
  end

  // Lamp output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_ff <= 1'b0;
    end else begin
      lamp_ff <= run && state_ff == FSA_BL_ON;
    end
  end

  assign lamp = lamp_ff;

endmodule

// ### verif/fsa_ctl_model.sv
// Behavioural laser controller driving enable, tickle and PWM
`timescale 1ns/1ns
module fsa_ctl_model (
  // Clock
  input wire logic pclk,
  // Bench requests
  input wire logic en_req,
  input wire logic fire,
  input wire logic [7:0] pwm_len,
  // Commands to the block
  output logic laser_enable = 1'b0,
  output logic tickle_cmd = 1'b0,
  output logic pwm_cmd = 1'b0
);
  logic [7:0] left_ff = 8'h00;
  logic [3:0] tick_ff = 4'h0;

  // Tickle keeps the tube primed between bursts
  always_ff @(posedge pclk) begin
    laser_enable <= en_req;
    tick_ff <= tick_ff + 4'h1;
    tickle_cmd <= tick_ff == 4'h0 && left_ff == 8'h00;
    left_ff <= fire ? pwm_len : (left_ff != 8'h00 ? left_ff - 8'h01 : 8'h00);
    pwm_cmd <= fire || left_ff > 8'h01;
  end
endmodule

// ### verif/fsa_annunciator_checker.sv
// Port assertions for the fault status annunciator
`timescale 1ns/1ns
module fsa_annunciator_checker #(
  parameter int PHASE_CYC = 8,
  parameter int MIN_PWM_CYC = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Inputs
  input wire logic over_temp,
  input wire logic pwm_sense,
  input wire logic laser_enable,
  input wire logic tickle_cmd,
  input wire logic pwm_cmd,
  // Outputs
  input wire logic rf_tickle,
  input wire logic rf_pwm,
  input wire logic ready_lamp,
  input wire logic power_lamp,
  input wire logic emission_lamp,
  input wire logic emitter_ok,
  input wire logic thermal_ok,
  input wire logic supply_ok
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic lamp_q_ff;
  int run_ff;

  // Length of the current power lamp phase during a code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_q_ff <= 1'b0;
      run_ff <= 0;
    end else begin
      lamp_q_ff <= power_lamp;
      run_ff <= (supply_ok || power_lamp != lamp_q_ff) ? 1 : run_ff + 1;
    end
  end

  a_ot_outputs: assert property ($rose(over_temp) |-> ##2 !thermal_ok && !emitter_ok && supply_ok && power_lamp)
    else $error("over temp outputs wrong");
  a_ot_latch: assert property ($fell(thermal_ok) |=> !thermal_ok [*8])
    else $error("fault not held");
  a_ot_dark: assert property (!thermal_ok [*3] |-> !emission_lamp && !rf_pwm && !rf_tickle)
    else $error("lasing during over temp");
  a_supply_out: assert property ((!supply_ok && thermal_ok) [*2] |-> !ready_lamp && !emitter_ok && !emission_lamp)
    else $error("supply fault outputs wrong");
  a_pwm_out: assert property ($rose(pwm_sense) |-> ##2 !emitter_ok && thermal_ok && supply_ok)
    else $error("pwm fault outputs wrong");
  a_idle_out: assert property ($fell(laser_enable) && emitter_ok |-> ##2 !ready_lamp && !emitter_ok && power_lamp)
    else $error("idle outputs wrong");
  a_enable_back: assert property ($rose(laser_enable) && thermal_ok && supply_ok && power_lamp |-> ##2 ready_lamp && emitter_ok)
    else $error("enable return not immediate");
  a_rf_gate: assert property (rf_pwm |-> $past(pwm_cmd) && $past(laser_enable) && thermal_ok && supply_ok)
    else $error("pwm passed without permit");
  a_tickle_pass: assert property (rf_tickle |-> $past(tickle_cmd))
    else $error("tickle without command");
  a_emit_min: assert property ($rose(emission_lamp) |-> pwm_cmd && $past(pwm_cmd, MIN_PWM_CYC))
    else $error("emission on short pulse");
  a_blink_on: assert property (!supply_ok && lamp_q_ff |-> run_ff <= PHASE_CYC + 1)
    else $error("blink on phase too long");
  a_blink_gap: assert property (!supply_ok && !lamp_q_ff |-> run_ff <= 2 * PHASE_CYC + 1)
    else $error("code gap too long");

  c_emission: cover property ($rose(emission_lamp));
  c_supply: cover property ($fell(supply_ok));
  c_thermal: cover property ($fell(thermal_ok));
endmodule

bind fsa_annunciator fsa_annunciator_checker #(.PHASE_CYC(PHASE_CYC), .MIN_PWM_CYC(MIN_PWM_CYC))
  u_fsa_annunciator_checker (.pclk, .presetn, .over_temp, .pwm_sense, .laser_enable, .tickle_cmd, .pwm_cmd,
  .rf_tickle, .rf_pwm, .ready_lamp, .power_lamp, .emission_lamp, .emitter_ok, .thermal_ok, .supply_ok);

// ### verif/test_fsa_annunciator.sv
// Self-checking bench for the fault status annunciator
`timescale 1ns/1ns
`include "fsa_defs.svh"
module test_fsa_annunciator;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [`FSA_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, irq, laser_enable, tickle_cmd, pwm_cmd, rf_tickle, rf_pwm;
  logic ready_lamp, power_lamp, emission_lamp, emitter_ok, thermal_ok, supply_ok;
  logic [4:0] fault = 5'h00;
  logic en_req = 1'b1, fire = 1'b0;
  logic [7:0] pwm_len = 8'h00;
  int error_cnt = 0, check_count = 0, r0, r1, r2;

  fsa_annunciator #(.PHASE_CYC(8), .MIN_PWM_CYC(3)) u_fsa_annunciator (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .over_temp(fault[0]), .under_volt(fault[1]),
    .over_volt(fault[2]), .dc_sense(fault[3]), .pwm_sense(fault[4]), .laser_enable, .tickle_cmd, .pwm_cmd,
    .rf_tickle, .rf_pwm, .ready_lamp, .power_lamp, .emission_lamp, .emitter_ok, .thermal_ok, .supply_ok, .irq);
  fsa_ctl_model u_fsa_ctl_model (.pclk, .en_req, .fire, .pwm_len, .laser_enable, .tickle_cmd, .pwm_cmd);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic [7:0] n);
    fire <= 1'b1;
    pwm_len <= n;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  task automatic rises(input int cyc);
    logic a, b;
    r0 = 0;
    r1 = 0;
    r2 = 0;
    a = ready_lamp;
    b = power_lamp;
    repeat (cyc) begin
      @(posedge pclk);
      if (ready_lamp && !a) r0++;
      if (power_lamp && !b) r1++;
      if (rf_tickle) r2++;
      a = ready_lamp;
      b = power_lamp;
    end
  endtask

  task automatic t_regs;
    apb(1'b0, `FSA_CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `FSA_CTRL_OFF, 32'h0);
    pulse(8'd4);
    repeat (3) @(posedge pclk);
    chk({rf_pwm, emission_lamp}, 2'b00);
    apb(1'b1, `FSA_CTRL_OFF, 32'h1);
    apb(1'b0, `FSA_IRQ_MASK_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd, er}, 33'h1);
  endtask

  task automatic t_normal;
    rises(32);
    chk({r0[7:0], r2[7:0], ready_lamp, power_lamp, emitter_ok, thermal_ok, supply_ok, emission_lamp},
        {8'h0, 8'h2, 6'b111110});
    pulse(8'd20);
    repeat (8) @(posedge pclk);
    chk({rf_pwm, emission_lamp}, 2'b11);
    repeat (24) @(posedge pclk);
    pulse(8'd2);
    repeat (2) @(posedge pclk);
    chk({rf_pwm, emission_lamp}, 2'b10);
  endtask

  task automatic t_enable;
    apb(1'b1, `FSA_IRQ_MASK_OFF, 32'h20);
    en_req <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({ready_lamp, power_lamp, emitter_ok, thermal_ok, supply_ok, irq}, 6'h17);
    apb(1'b1, `FSA_IRQ_STAT_OFF, 32'h20);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    en_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({ready_lamp, emitter_ok}, 2'b11);
  endtask

  task automatic t_fault(input logic [4:0] f, input int per, input int rn, input int pn, input logic [2:0] okv);
    do_reset;
    fault <= f;
    @(posedge pclk);
    fault <= 5'h00;
    repeat (4) @(posedge pclk);
    chk({emitter_ok, thermal_ok, supply_ok, emission_lamp}, {okv, 1'b0});
    apb(1'b0, `FSA_STATUS_OFF, 32'h0);
    chk(rd[4:0], f);
    pulse(8'd20);
    repeat (8) @(posedge pclk);
    chk({rf_pwm, emission_lamp}, 2'b00);
    apb(1'b1, `FSA_IRQ_MASK_OFF, 32'h1f);
    repeat (40) @(posedge pclk);
    chk(irq, 1'b1);
    rises(2 * per * 8);
    chk({r0, r1}, {rn, pn});
    chk(r2, 0);
    if (pn == 0) chk(power_lamp, 1'b1);
  endtask

  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end

  initial begin
    do_reset;
    t_regs;
    t_normal;
    t_enable;
    t_fault(5'h01, 2, 2, 0, 3'b001);
    t_fault(5'h02, 3, 0, 2, 3'b010);
    t_fault(5'h04, 5, 0, 4, 3'b010);
    t_fault(5'h08, 7, 0, 6, 3'b010);
    t_fault(5'h10, 2, 2, 2, 3'b011);
    t_fault(5'h06, 3, 0, 2, 3'b010);
    do_reset;
    @(posedge pclk);
    chk({emitter_ok, thermal_ok, supply_ok}, 3'b111);
    stop_test;
  end
endmodule
